/* pkg/pbcaf_cfg.svh */
// bit positions, counts and defaults of the command-address front end
// assumes inclusion by every design file that decodes the header or counts edges
//
// Behaviour
// - falling select starts a new transaction
// - rising select ends the transaction and releases the pins
// - link clock may stop between transactions
// - low-voltage parts sample at crossing of clock pair, others use true clock
// - during header the strobe is driven high for extra latency, else low
// - during read data the strobe toggles with each driven byte
// - during write data the strobe is an input used as byte mask
// - hardware reset low initialises and returns to standby
// - hardware reset low releases strobe and data lines
// - open hardware reset input counts as high
// - six header bytes on six edges, most significant first
// - header byte bit order follows data line numbering
// - header bit 47 one is read, zero is write
// - header bit 46 zero is memory, one is register space
// - register space reaches identity and configuration registers
// - header bit 45 zero is wrapped burst, one linear
// - header bits 35 to 22 give row address
// - header bits 21 to 16 give upper column address
// - header bits 2 to 0 give starting word
// - write byte with strobe high is masked, low is written
// - wrapped burst wraps in its aligned group; linear runs until select rises
`ifndef PBCAF_CFG_SVH
`define PBCAF_CFG_SVH

// ==========================================
// header layout
`define PBCAF_HDR_W      48
`define PBCAF_RW_BIT     47
`define PBCAF_SPACE_BIT  46
`define PBCAF_BURST_BIT  45
`define PBCAF_ROW_HI     35
`define PBCAF_ROW_LO     22
`define PBCAF_UCOL_HI    21
`define PBCAF_UCOL_LO    16
`define PBCAF_LCOL_HI    2
`define PBCAF_LCOL_LO    0
`define PBCAF_HDR_LAST   4'h5

// ==========================================
// defaults
`define PBCAF_LAT_CLKS   6
`define PBCAF_WRAP_WORDS 8
`define PBCAF_FIFO_DEPTH 4

`endif

/* pkg/pbcaf_pkg.sv */
// types shared by the front end, its synchroniser and its write buffer
// assumes the cfg header is compiled alongside
`include "pbcaf_cfg.svh"
package pbcaf_pkg;

    // ==========================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HDR,
        ST_LAT,
        ST_RD,
        ST_WR
    } pbcaf_state_t;

    typedef struct packed {
        logic        read;
        logic        regSpace;
        logic        linear;
        logic [13:0] row;
        logic [5:0]  upperCol;
        logic [2:0]  lowerCol;
    } pbcaf_hdr_t;

    typedef struct packed {
        logic       mask;
        logic [7:0] data;
    } pbcaf_wbyte_t;

    typedef struct packed {
        logic csN;
        logic ck;
        logic ckComp;
        logic strobe;
        logic [7:0] dq;
        logic resetN;
    } pbcaf_pins_t;

endpackage

/* rtl/pbcaf_sync.sv */
// two-stage synchroniser for a packed group of pin levels
// assumes every bit is an asynchronous level; reset value is a constant
`timescale 1ns/10ps
module pbcaf_sync #(
    parameter int               W   = 13,
    parameter logic [W-1:0]     RST = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_sync;

    // ==========================================
    // stage one is read only by stage two
    always_comb begin
        nxt_meta = din;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_ff <= RST;
            sync_ff <= RST;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign dout = sync_ff;
endmodule

/* rtl/pbcaf_fifo.sv */
// small show-ahead fifo, outputs straight from flops
// assumes push only when inReady, pop only when outValid
`timescale 1ns/10ps
`include "pbcaf_cfg.svh"
module pbcaf_fifo
    import pbcaf_pkg::*;
#(
    parameter int W     = 9,
    parameter int DEPTH = `PBCAF_FIFO_DEPTH
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic         inValid,
    input  wire logic [W-1:0] inData,
    output logic              inReady,
    output logic              outValid,
    output logic      [W-1:0] outData,
    input  wire logic         outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic [AW:0]   cnt_ff, nxt_cnt;
    logic          full_ff, nxt_full, val_ff, nxt_val;
    logic [W-1:0]  dat_ff, nxt_dat;
    logic          push, pop;

    // ==========================================
    // pointers and flags; data of the head entry is re-read every cycle
    always_comb begin
        push     = inValid && !full_ff;
        pop      = outReady && val_ff;
        nxt_wr   = push ? AW'(wr_ff + 1'b1) : wr_ff;
        nxt_rd   = pop ? AW'(rd_ff + 1'b1) : rd_ff;
        nxt_cnt  = (AW+1)'(cnt_ff + push - pop);
        nxt_full = nxt_cnt == (AW+1)'(DEPTH);
        nxt_val  = nxt_cnt != '0;
        // bypass: entry being written is the new head
        nxt_dat  = (push && nxt_rd == wr_ff) ? inData : mem[nxt_rd];
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ff] <= inData;
        end
        if (srst) begin
            wr_ff   <= '0;
            rd_ff   <= '0;
            cnt_ff  <= '0;
            full_ff <= 1'b0;
            val_ff  <= 1'b0;
            dat_ff  <= '0;
        end else begin
            wr_ff   <= nxt_wr;
            rd_ff   <= nxt_rd;
            cnt_ff  <= nxt_cnt;
            full_ff <= nxt_full;
            val_ff  <= nxt_val;
            dat_ff  <= nxt_dat;
        end
    end

    assign inReady  = !full_ff;
    assign outValid = val_ff;
    assign outData  = dat_ff;

    fifo_full_a: assert property (@(posedge sys_clk) disable iff (srst)
        full_ff |-> cnt_ff == (AW+1)'(DEPTH))
        else $error("fifo full flag disagrees with count");
endmodule

/* rtl/pbcaf_top.sv */
// slave front end of the ddr command-address bus: framing, header decode,
// strobe roles, burst addressing and a buffered write byte stream
// assumes pins arrive asynchronously and the link clock is far below sys_clk
`timescale 1ns/10ps
`include "pbcaf_cfg.svh"
module pbcaf_top #(
    parameter int   LAT_CLKS   = `PBCAF_LAT_CLKS,
    parameter int   WRAP_WORDS = `PBCAF_WRAP_WORDS,
    parameter int   FIFO_DEPTH = `PBCAF_FIFO_DEPTH,
    parameter logic DIFF_CLK   = 1'b1
) (
    input  wire logic                 sys_clk,
    input  wire logic                 srst,
    input  wire logic                 csN,
    input  wire logic                 linkClk,
    input  wire logic                 clock_complement,
    input  wire logic                 resetN,
    input  wire logic [7:0]           dqIn,
    output logic      [7:0]           dqOut,
    output logic                      dqOeN,
    input  wire logic                 rw_data_strobe_in,
    output logic                      strobeOut,
    output logic                      strobeOeN,
    input  wire logic                 refreshReq,
    input  wire logic [7:0]           rdByte,
    output logic                      rdTake,
    output pbcaf_pkg::pbcaf_hdr_t     header,
    output logic                      headerValid,
    output logic [22:0]               wordAddr,
    output logic                      standby,
    output logic                      wrOverrun,
    output logic                      wrValid,
    output pbcaf_pkg::pbcaf_wbyte_t   wrByte,
    input  wire logic                 wrReady
);
    import pbcaf_pkg::*;

    localparam logic [7:0]  LAT_EDGES = 8'(2 * LAT_CLKS);
    localparam logic [22:0] WRAP_MASK = 23'(WRAP_WORDS - 1);

    // ==========================================
    // pin synchroniser
    pbcaf_pins_t pinRaw, pinS;
    logic        fifoReady;

    always_comb begin
        pinRaw.csN    = csN;
        pinRaw.ck     = linkClk;
        pinRaw.ckComp = clock_complement;
        pinRaw.strobe = rw_data_strobe_in;
        pinRaw.dq     = dqIn;
        pinRaw.resetN = resetN;
    end

    // select and reset sit high in reset: an open reset pin reads deasserted
    pbcaf_sync #(
        .W   ($bits(pbcaf_pins_t)),
        .RST ({1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 1'b1})
    ) uSync (
        .sys_clk (sys_clk),
        .srst    (srst),
        .din     (pinRaw),
        .dout    (pinS)
    );

    // ==========================================
    // edge detection on synchronised pins
    logic clkLvl, clkPrev_ff, nxt_clkPrev, csPrev_ff, nxt_csPrev;
    logic linkEdge, csFall, csRise, pinRst;

    // pair crossing for differential parts, true clock alone otherwise
    always_comb begin
        clkLvl      = DIFF_CLK ? (pinS.ck && !pinS.ckComp) : pinS.ck;
        nxt_clkPrev = clkLvl;
        nxt_csPrev  = pinS.csN;
        linkEdge    = clkLvl != clkPrev_ff;
        csFall      = csPrev_ff && !pinS.csN;
        csRise      = !csPrev_ff && pinS.csN;
        pinRst      = !pinS.resetN;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            clkPrev_ff <= 1'b0;
            csPrev_ff  <= 1'b1;
        end else begin
            clkPrev_ff <= nxt_clkPrev;
            csPrev_ff  <= nxt_csPrev;
        end
    end

    // ==========================================
    // transaction engine
    pbcaf_state_t state_ff, nxt_state;
    logic [47:0]  shift_ff, nxt_shift;
    logic [3:0]   edgeCnt_ff, nxt_edgeCnt;
    logic [7:0]   lat_ff, nxt_lat;
    logic         byteB_ff, nxt_byteB;
    logic [7:0]   dq_ff, nxt_dq;
    logic         dqOe_ff, nxt_dqOe, rw_ff, nxt_rw, rwOe_ff, nxt_rwOe;
    pbcaf_hdr_t   hdr_ff, nxt_hdr;
    logic         hdrV_ff, nxt_hdrV, take_ff, nxt_take, ovr_ff, nxt_ovr;
    logic [22:0]  addr_ff, nxt_addr, addrInc;
    logic         push_ff, nxt_push;
    logic         idle_ff, nxt_idle;
    pbcaf_wbyte_t wb_ff, nxt_wb;

    // wrapped bursts stay inside their aligned group; linear just counts
    always_comb begin
        addrInc = addr_ff + 23'h000001;
        if (!hdr_ff.linear) begin
            addrInc = (addr_ff & ~WRAP_MASK) | (addrInc & WRAP_MASK);
        end
    end

    // the link cannot be stalled, so a full buffer drops the byte and flags it
    always_comb begin
        nxt_state   = state_ff;
        nxt_shift   = shift_ff;
        nxt_edgeCnt = edgeCnt_ff;
        nxt_lat     = lat_ff;
        nxt_byteB   = byteB_ff;
        nxt_dq      = dq_ff;
        nxt_dqOe    = dqOe_ff;
        nxt_rw      = rw_ff;
        nxt_rwOe    = rwOe_ff;
        nxt_hdr     = hdr_ff;
        nxt_hdrV    = 1'b0;
        nxt_take    = 1'b0;
        nxt_ovr     = ovr_ff;
        nxt_addr    = addr_ff;
        nxt_push    = 1'b0;
        nxt_wb      = wb_ff;
        if (pinRst || csRise) begin
            // release both pin groups and return to standby
            nxt_state = ST_IDLE;
            nxt_dqOe  = 1'b1;
            nxt_rwOe  = 1'b1;
            nxt_rw    = 1'b0;
            if (pinRst) begin
                nxt_ovr = 1'b0;
            end
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    // nothing here waits on the link clock
                    if (csFall) begin
                        nxt_state   = ST_HDR;
                        nxt_edgeCnt = 4'h0;
                        nxt_byteB   = 1'b0;
                        nxt_rw      = refreshReq;
                        nxt_rwOe    = 1'b0;
                        nxt_ovr     = 1'b0;
                    end
                end
                ST_HDR: begin
                    nxt_rw = refreshReq;
                    if (linkEdge) begin
                        nxt_shift   = {shift_ff[39:0], pinS.dq};
                        nxt_edgeCnt = edgeCnt_ff + 4'h1;
                        if (edgeCnt_ff == `PBCAF_HDR_LAST) begin
                            nxt_hdr.read     = nxt_shift[`PBCAF_RW_BIT];
                            nxt_hdr.regSpace = nxt_shift[`PBCAF_SPACE_BIT];
                            nxt_hdr.linear   = nxt_shift[`PBCAF_BURST_BIT];
                            nxt_hdr.row      =
                                nxt_shift[`PBCAF_ROW_HI:`PBCAF_ROW_LO];
                            nxt_hdr.upperCol =
                                nxt_shift[`PBCAF_UCOL_HI:`PBCAF_UCOL_LO];
                            nxt_hdr.lowerCol =
                                nxt_shift[`PBCAF_LCOL_HI:`PBCAF_LCOL_LO];
                            nxt_addr  = {nxt_hdr.row, nxt_hdr.upperCol, nxt_hdr.lowerCol};
                            nxt_hdrV  = 1'b1;
                            nxt_state = ST_LAT;
                            nxt_lat   = rw_ff ? 8'(2 * LAT_EDGES) : LAT_EDGES;
                            // writes hand the strobe to the host
                            nxt_rwOe  = !nxt_hdr.read;
                        end
                    end
                end
                ST_LAT: begin
                    if (linkEdge) begin
                        nxt_lat = lat_ff - 8'h01;
                        if (lat_ff == 8'h01) begin
                            nxt_state = hdr_ff.read ? ST_RD : ST_WR;
                            nxt_rw    = 1'b0;
                        end
                    end
                end
                ST_RD: begin
                    if (linkEdge) begin
                        nxt_dq    = rdByte;
                        nxt_dqOe  = 1'b0;
                        nxt_rw    = !rw_ff;
                        nxt_take  = 1'b1;
                        nxt_byteB = !byteB_ff;
                        if (byteB_ff) begin
                            nxt_addr = addrInc;
                        end
                    end
                end
                ST_WR: begin
                    if (linkEdge) begin
                        nxt_wb.mask = pinS.strobe;
                        nxt_wb.data = pinS.dq;
                        nxt_push    = fifoReady;
                        nxt_ovr     = ovr_ff || !fifoReady;
                        nxt_byteB   = !byteB_ff;
                        if (byteB_ff) begin
                            nxt_addr = addrInc;
                        end
                    end
                end
            endcase
        end
        // standby registered so the output comes straight from a flop
        nxt_idle = nxt_state == ST_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff   <= ST_IDLE;
            idle_ff    <= 1'b1;
            shift_ff   <= 48'h000000000000;
            edgeCnt_ff <= 4'h0;
            lat_ff     <= 8'h00;
            byteB_ff   <= 1'b0;
            dq_ff      <= 8'h00;
            dqOe_ff    <= 1'b1;
            rw_ff      <= 1'b0;
            rwOe_ff    <= 1'b1;
            hdr_ff     <= '0;
            hdrV_ff    <= 1'b0;
            take_ff    <= 1'b0;
            ovr_ff     <= 1'b0;
            addr_ff    <= 23'h000000;
            push_ff    <= 1'b0;
            wb_ff      <= '0;
        end else begin
            state_ff   <= nxt_state;
            idle_ff    <= nxt_idle;
            shift_ff   <= nxt_shift;
            edgeCnt_ff <= nxt_edgeCnt;
            lat_ff     <= nxt_lat;
            byteB_ff   <= nxt_byteB;
            dq_ff      <= nxt_dq;
            dqOe_ff    <= nxt_dqOe;
            rw_ff      <= nxt_rw;
            rwOe_ff    <= nxt_rwOe;
            hdr_ff     <= nxt_hdr;
            hdrV_ff    <= nxt_hdrV;
            take_ff    <= nxt_take;
            ovr_ff     <= nxt_ovr;
            addr_ff    <= nxt_addr;
            push_ff    <= nxt_push;
            wb_ff      <= nxt_wb;
        end
    end

    // ==========================================
    // write byte buffer
    pbcaf_fifo #(
        .W     ($bits(pbcaf_wbyte_t)),
        .DEPTH (FIFO_DEPTH)
    ) uFifo (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .inValid  (push_ff),
        .inData   (wb_ff),
        .inReady  (fifoReady),
        .outValid (wrValid),
        .outData  (wrByte),
        .outReady (wrReady)
    );

    // outputs
    assign dqOut       = dq_ff;
    assign dqOeN       = dqOe_ff;
    assign strobeOut   = rw_ff;
    assign strobeOeN   = rwOe_ff;
    assign rdTake      = take_ff;
    assign header      = hdr_ff;
    assign headerValid = hdrV_ff;
    assign wordAddr    = addr_ff;
    assign standby     = idle_ff;
    assign wrOverrun   = ovr_ff;

    // ==========================================
    // checks
    cs_start_a: assert property (@(posedge sys_clk) disable iff (srst)
        state_ff == ST_IDLE && csFall && !pinRst |=> state_ff == ST_HDR && !rwOe_ff)
        else $error("select fall did not start header phase");
    cs_end_a: assert property (@(posedge sys_clk) disable iff (srst)
        csRise |=> state_ff == ST_IDLE && dqOe_ff && rwOe_ff)
        else $error("select rise did not end transaction");
    hdr_latency_a: assert property (@(posedge sys_clk) disable iff (srst)
        state_ff == ST_HDR && !csRise && !pinRst |=> rw_ff == $past(refreshReq))
        else $error("strobe does not show refresh latency in header");
    rd_toggle_a: assert property (@(posedge sys_clk) disable iff (srst)
        state_ff == ST_RD && linkEdge && !csRise && !pinRst
        |=> rw_ff != $past(rw_ff) && take_ff && !dqOe_ff)
        else $error("read strobe failed to toggle with data");
    wr_mask_a: assert property (@(posedge sys_clk) disable iff (srst)
        push_ff |-> wb_ff.mask == $past(pinS.strobe) && rwOe_ff)
        else $error("write mask not taken from strobe");
    pin_release_a: assert property (@(posedge sys_clk) disable iff (srst)
        pinRst |=> dqOe_ff && rwOe_ff && state_ff == ST_IDLE)
        else $error("pins not released under hardware reset");
    rw_decode_a: assert property (@(posedge sys_clk) disable iff (srst)
        hdrV_ff |-> hdr_ff.read == shift_ff[`PBCAF_RW_BIT]
            && hdr_ff.row == shift_ff[`PBCAF_ROW_HI:`PBCAF_ROW_LO]
            && wordAddr[2:0] == shift_ff[`PBCAF_LCOL_HI:`PBCAF_LCOL_LO])
        else $error("header decode mismatch");
    wrap_group_a: assert property (@(posedge sys_clk) disable iff (srst)
        (state_ff == ST_RD || state_ff == ST_WR) && !hdr_ff.linear
        |=> (addr_ff & ~WRAP_MASK) == ($past(addr_ff) & ~WRAP_MASK))
        else $error("wrapped burst left its group");
    six_edges_a: assert property (@(posedge sys_clk) disable iff (srst)
        hdrV_ff |-> $past(edgeCnt_ff) == `PBCAF_HDR_LAST && $past(linkEdge))
        else $error("header not complete after six edges");

    read_cov_c: cover property (@(posedge sys_clk) disable iff (srst)
        state_ff == ST_RD && take_ff);
    write_cov_c: cover property (@(posedge sys_clk) disable iff (srst)
        push_ff && !wb_ff.mask);
    extra_cov_c: cover property (@(posedge sys_clk) disable iff (srst)
        hdrV_ff && rw_ff);
endmodule

/* bench/pbcaf_host.sv */
// host controller model: select framing, link clock, header and write data
// assumes the bench resolves shared lines from the device output enables
`timescale 1ns/10ps
module pbcaf_host (
    input  wire logic       sys_clk,
    output logic            csN,
    output logic            linkClk,
    output logic            clock_complement,
    output logic            strobe,
    output logic [7:0]      dq
);
    // ==========================================
    // pins
    // complement follows true clock, so an idle clock is low/high
    assign clock_complement = ~linkClk;
    initial begin
        csN = 1'b1;
        linkClk = 1'b0;
        strobe = 1'b0;
        dq = 8'hA5;
    end
    // one edge, data centred; a released line flips so no stale value hides
    task automatic step(input logic [7:0] d, input logic m, input logic drvD,
                        input logic drvS);
        dq = drvD ? d : ~dq;
        strobe = drvS ? m : ~strobe;
        repeat (2) @(negedge sys_clk);
        linkClk = ~linkClk;
        repeat (2) @(negedge sys_clk);
    endtask
    // clock may run while deselected; the device must ignore it
    task automatic stray();
        repeat (2) step(8'h00, 1'b0, 1'b0, 1'b0);
    endtask
    // select with idle clock, then six header bytes high byte first
    task automatic open(input logic [47:0] h);
        csN = 1'b0;
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < 6; i++) begin
            step(h[47 - 8 * i -: 8], 1'b0, 1'b1, 1'b0);
        end
    endtask
    // latency edges carry nothing
    task automatic lat(input int n);
        repeat (n) step(8'h00, 1'b0, 1'b0, 1'b0);
    endtask
    // end of frame
    task automatic close();
        repeat (2) @(negedge sys_clk);
        csN = 1'b1;
        dq = ~dq;
        strobe = ~strobe;
    endtask
endmodule

/* bench/psram_bus_cmd_addr_frontend_tb.sv */
// bench for the command-address front end: host model and queued checks
// assumes the design files and pbcaf_host are compiled before it
`timescale 1ns/10ps
module psram_bus_cmd_addr_frontend_tb;
    import pbcaf_pkg::*;
    localparam int L = 2;
    logic         sys_clk, srst, resetN, refreshReq, wrReady, stall, rdPar;
    logic         csN, linkClk, ckc, hStrobe, strobeIn, dqOeN, strobeOut, strobeOeN;
    logic         rdTake, headerValid, standby, wrOverrun, wrValid;
    logic [7:0]   hDq, dqIn, dqOut, rdByte;
    logic [22:0]  wordAddr;
    pbcaf_hdr_t   header;
    pbcaf_wbyte_t wrByte;
    pbcaf_hdr_t   hq[$];
    pbcaf_wbyte_t wq[$];
    logic [7:0]   rq[$];
    int           miscompares = 0;
    int           n_compared = 0;
    // ==========================================
    // clock and wiring
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // whoever has its enable low owns the wire
    assign dqIn = dqOeN ? hDq : dqOut;
    assign strobeIn = strobeOeN ? hStrobe : strobeOut;
    pbcaf_top #(.LAT_CLKS(L)) i_pbcaf_top (
        .sys_clk(sys_clk), .srst(srst), .csN(csN), .linkClk(linkClk),
        .clock_complement(ckc), .resetN(resetN), .dqIn(dqIn), .dqOut(dqOut),
        .dqOeN(dqOeN), .rw_data_strobe_in(strobeIn), .strobeOut(strobeOut),
        .strobeOeN(strobeOeN), .refreshReq(refreshReq), .rdByte(rdByte),
        .rdTake(rdTake), .header(header), .headerValid(headerValid),
        .wordAddr(wordAddr), .standby(standby), .wrOverrun(wrOverrun),
        .wrValid(wrValid), .wrByte(wrByte), .wrReady(wrReady));
    pbcaf_host i_pbcaf_host (.sys_clk(sys_clk), .csN(csN), .linkClk(linkClk),
        .clock_complement(ckc), .strobe(hStrobe), .dq(hDq));
    // ==========================================
    // compare and verdict
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // monitor: each result takes the oldest note
    always @(posedge sys_clk) begin
        if (headerValid) chk("header", header, hq.pop_front());
        if (rdTake) begin
            chk("rdData", dqOut, rq.pop_front());
            chk("rdStrobe", {dqOeN, strobeOut}, {1'b0, rdPar});
            rdPar = ~rdPar;
        end
        if (wrValid && wrReady) chk("wrByte", wrByte, wq.pop_front());
    end
    // sink stalls at random; read byte renewed only after the device took one
    always @(negedge sys_clk) begin
        wrReady <= stall ? 1'b0 : 1'($urandom);
        if (rdTake) begin
            rdByte = 8'($urandom);
            rq.push_back(rdByte);
        end
    end
    // one transaction; hw pulls the pin reset after the last data edge, with select still low, instead of checking the address
    task automatic xfer(input logic rd, input int n, input int keep, input logic hw);
        logic sp, ln;
        logic [13:0] row;
        logic [5:0] uc;
        logic [2:0] lc;
        logic [22:0] a;
        pbcaf_wbyte_t w;
        sp = 1'($urandom);
        ln = 1'($urandom);
        row = 14'($urandom);
        uc = 6'($urandom);
        lc = 3'($urandom);
        refreshReq = 1'($urandom);
        hq.push_back(pbcaf_hdr_t'{rd, sp, ln, row, uc, lc});
        rq.delete();
        rdByte = 8'($urandom);
        rq.push_back(rdByte);
        rdPar = 1'b1;
        i_pbcaf_host.stray();
        i_pbcaf_host.open({rd, sp, ln, 9'h000, row, uc, 13'h0000, lc});
        chk("hdrStrobe", {strobeOeN, strobeOut, wrOverrun}, {1'b0, refreshReq, 1'b0});
        i_pbcaf_host.lat(refreshReq ? 4 * L : 2 * L);
        for (int k = 0; k < n; k++) begin
            w = 9'($urandom);
            if (!rd && k < keep) wq.push_back(w);
            i_pbcaf_host.step(w.data, w.mask, !rd, !rd);
        end
        a = ln ? {row, uc, lc} + 23'(n / 2) : {row, uc, 3'(lc + n / 2)};
        repeat (6) @(negedge sys_clk);
        chk("dataDir", {dqOeN, strobeOeN}, rd ? 2'b00 : 2'b11);
        if (hw) begin
            resetN = 1'b0;
            repeat (6) @(negedge sys_clk);
            chk("pinReset", {dqOeN, strobeOeN, standby}, 3'b111);
            resetN = 1'b1;
        end else chk("wordAddr", wordAddr, a);
        i_pbcaf_host.close();
        repeat (6) @(negedge sys_clk);
        chk("released", {dqOeN, strobeOeN, standby}, 3'b111);
    endtask
    // ==========================================
    // tests
    initial begin
        srst = 1'b1;
        resetN = 1'b1;
        refreshReq = 1'b0;
        stall = 1'b0;
        rdByte = 8'h00;
        rdPar = 1'b1;
        wrReady = 1'b0;
        void'($urandom(32'hC27C));
        repeat (10) @(negedge sys_clk);
        srst = 1'b0;
        for (int i = 0; i < 6; i++) xfer(i[0], 10, 10, 1'b0);
        $display("test bursts done");
        // link cannot stall: a full buffer drops bytes and flags it
        stall = 1'b1;
        xfer(1'b0, 6, 4, 1'b0);
        chk("overrun", wrOverrun, 1'b1);
        stall = 1'b0;
        repeat (40) @(negedge sys_clk);
        chk("drained", wq.size(), 0);
        $display("test overflow done");
        xfer(1'b1, 2, 0, 1'b1);
        $display("test pin reset done");
        results();
    end
    // watchdog well beyond the expected run
    initial begin
        #200000;
        miscompares++;
        results();
    end
endmodule
